//--- bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        CLK, SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic        CHIP_SELECT_N, OSC_INPUT, AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic        SERIAL_IN, SERIAL_OUT, CTS_N, DSR_N, DTR_N, RTS_N, CLOCK_OUTPUT_PIN;
	logic        TX_BUFFER_EMPTY, RX_CHAR_AVAILABLE, IRQ_OUTPUT;
	logic [3:0]  AWADDR, ARADDR, WSTRB;
	logic [1:0]  BRESP, RRESP;
	logic [31:0] WDATA, RDATA;
	logic [7:0]  b, b2;	// Read back and caught bytes
	int          err_count, comparisons, n, lo;
	// Short tick divider keeps frames at 320 clocks
	upc_top #(.BIT_DIV(16'h0001)) i_upc_top (.*);
	upc_line #(.BT(32)) i_upc_line (.*);
	initial
	begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	task end_sim();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task wt(input int k);
		repeat (k) @(posedge CLK);
	endtask
	task tmo();
		err_count++;
		$display("BAD %0t wait ran out", $time);
		end_sim();
	endtask
	// Write: address and data offered together, each dropped when taken
	task wr(input logic [3:0] a, input logic [7:0] d);
		AWADDR <= a;
		WDATA <= {24'h0, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
			if (BVALID) break;
		end
		if (n == 50) tmo();
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		ARADDR <= a;
		ARVALID <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLK);
			if (ARREADY) ARVALID <= 1'b0;
			if (RVALID) break;
		end
		d = RDATA[7:0];
		if (n == 50) tmo();
	endtask
	// Count low samples on the transmit pin
	task watch(input int k, output int c);
		c = 0;
		repeat (k)
		begin
			@(posedge CLK);
			if (!SERIAL_OUT) c++;
		end
	endtask
	task done(input int t);
		$display("test %0d done", t);
	endtask
	initial
	begin
		SRST = 1'b1;
		{AWVALID, WVALID, ARVALID, CHIP_SELECT_N, OSC_INPUT} = 5'h00;
		{BREADY, RREADY} = 2'h3;
		{AWADDR, ARADDR, WSTRB, WDATA} = {8'h00, 4'hf, 32'h0};
		wt(6);
		SRST <= 1'b0;
		wt(1);
		rd(upc_pkg::OFF_STAT, b);
		chk(b, 8'h06);
		rd(upc_pkg::OFF_MCTL, b);
		chk(b, 8'h00);
		done(1);
		// Control pins, chip select, reset in mid-run
		wr(upc_pkg::OFF_MCTL, 8'h01);
		wt(2);
		chk({6'h0, DTR_N, RTS_N}, 8'h01);
		wr(upc_pkg::OFF_MCTL, 8'h02);
		wt(2);
		chk({6'h0, DTR_N, RTS_N}, 8'h02);
		wr(upc_pkg::OFF_MCTL, 8'h03);
		CHIP_SELECT_N <= 1'b1;
		wr(upc_pkg::OFF_MCTL, 8'h00);
		CHIP_SELECT_N <= 1'b0;
		wt(2);
		chk({6'h0, DTR_N, RTS_N}, 8'h00);
		rd(upc_pkg::OFF_MCTL, b);
		chk(b, 8'h03);
		SRST <= 1'b1;
		wt(2);
		SRST <= 1'b0;
		wt(2);
		chk({6'h0, DTR_N, RTS_N}, 8'h03);
		done(2);
		// Modem status and interrupt gating
		i_upc_line.modem(1'b0, 1'b1);
		wt(4);
		rd(upc_pkg::OFF_BAUD, b);
		chk(b, 8'h01);
		i_upc_line.modem(1'b0, 1'b0);
		wt(4);
		rd(upc_pkg::OFF_BAUD, b);
		chk(b, 8'h03);
		wr(upc_pkg::OFF_MCTL, 8'h18);
		wt(2);
		chk({7'h0, IRQ_OUTPUT}, 8'h00);
		i_upc_line.modem(1'b0, 1'b1);
		wt(5);
		chk({7'h0, IRQ_OUTPUT}, 8'h01);
		wr(upc_pkg::OFF_MCTL, 8'h10);
		wt(2);
		chk({7'h0, IRQ_OUTPUT}, 8'h00);
		wr(upc_pkg::OFF_MCTL, 8'h08);
		wt(2);
		chk({7'h0, IRQ_OUTPUT}, 8'h00);
		wr(upc_pkg::OFF_MCTL, 8'h18);
		wt(2);
		chk({7'h0, IRQ_OUTPUT}, 8'h01);
		rd(upc_pkg::OFF_BAUD, b);
		wt(3);
		chk({7'h0, IRQ_OUTPUT}, 8'h00);
		wr(upc_pkg::OFF_MCTL, 8'h00);
		done(3);
		// Back to back characters, empty flag held low
		fork
			begin
				i_upc_line.grab(b);
				i_upc_line.grab(b2);
			end
			begin
				wr(upc_pkg::OFF_TXRX, 8'ha5);
				wt(40);
				wr(upc_pkg::OFF_TXRX, 8'h81);
				wt(3);
				chk({7'h0, TX_BUFFER_EMPTY}, 8'h00);
			end
		join
		chk(b, 8'ha5);
		chk(b2, 8'h81);
		wt(40);
		chk({7'h0, TX_BUFFER_EMPTY}, 8'h01);
		done(4);
		// Clear-to-send false holds the line; in-flight char completes
		i_upc_line.modem(1'b1, 1'b1);
		fork
			watch(400, lo);
			wr(upc_pkg::OFF_TXRX, 8'hc3);
		join
		chk({7'h0, lo == 0}, 8'h01);
		fork
			i_upc_line.grab(b);
			begin
				i_upc_line.modem(1'b0, 1'b1);
				wt(150);
				i_upc_line.modem(1'b1, 1'b1);
			end
		join
		chk(b, 8'hc3);
		done(5);
		// Receive path
		i_upc_line.send(8'h3c);
		for (n = 0; n < 99 && !RX_CHAR_AVAILABLE; n++) wt(1);
		chk({7'h0, RX_CHAR_AVAILABLE}, 8'h01);
		// Deselected read returns zero and leaves data ready set
		CHIP_SELECT_N <= 1'b1;
		rd(upc_pkg::OFF_TXRX, b);
		CHIP_SELECT_N <= 1'b0;
		chk({b[6:0], RX_CHAR_AVAILABLE}, 8'h01);
		rd(upc_pkg::OFF_TXRX, b);
		chk(b, 8'h3c);
		wt(2);
		chk({7'h0, RX_CHAR_AVAILABLE}, 8'h00);
		done(6);
		// Loop test with clear-to-send still false
		wr(upc_pkg::OFF_MCTL, 8'h04);
		fork
			watch(500, lo);
			wr(upc_pkg::OFF_TXRX, 8'h5a);
		join
		chk({7'h0, lo == 0}, 8'h01);
		for (n = 0; n < 99 && !RX_CHAR_AVAILABLE; n++) wt(1);
		rd(upc_pkg::OFF_TXRX, b);
		chk(b, 8'h5a);
		wr(upc_pkg::OFF_MCTL, 8'h00);
		done(7);
		// Clock output source select
		wr(upc_pkg::OFF_BAUD, 8'h80);
		wt(1);
		b[0] = CLOCK_OUTPUT_PIN;
		wt(2);
		chk({7'h0, CLOCK_OUTPUT_PIN ^ b[0]}, 8'h01);
		// Reset alone must bring the oscillator back on the pin
		SRST <= 1'b1;
		wt(2);
		SRST <= 1'b0;
		OSC_INPUT <= 1'b1;
		wt(4);
		chk({7'h0, CLOCK_OUTPUT_PIN}, 8'h01);
		OSC_INPUT <= 1'b0;
		wt(4);
		chk({7'h0, CLOCK_OUTPUT_PIN}, 8'h00);
		done(8);
		end_sim();
	end
endmodule // tb
`default_nettype wire

//--- bench/upc_line.sv
`timescale 1ns/100ps
`default_nettype none
module upc_line #(
	parameter int BT = 32	// Clocks per bit
) (
	input  wire logic CLK,
	input  wire logic SERIAL_OUT,
	output var  logic SERIAL_IN,
	output var  logic CTS_N,
	output var  logic DSR_N
);
	// Line rests at mark, modem lines false
	initial
	begin
		SERIAL_IN = 1'b1;
		CTS_N = 1'b1;
		DSR_N = 1'b1;
	end
	// Modem line levels, changed just after an edge
	task modem(input logic c, input logic d);
		@(posedge CLK);
		CTS_N <= c;
		DSR_N <= d;
	endtask
	// One 8N1 frame onto the receive pin
	task send(input logic [7:0] v);
		int i;
		@(posedge CLK);
		SERIAL_IN <= 1'b0;
		repeat (BT) @(posedge CLK);
		for (i = 0; i < 8; i++)
		begin
			SERIAL_IN <= v[i];
			repeat (BT) @(posedge CLK);
		end
		SERIAL_IN <= 1'b1;
		repeat (BT) @(posedge CLK);
	endtask
	// Catch one frame; unknown on timeout or bad stop
	task grab(output logic [7:0] v);
		int i;
		v = 8'hxx;
		for (i = 0; i < 3000 && SERIAL_OUT; i++) @(posedge CLK);
		if (!SERIAL_OUT)
		begin
			repeat (BT / 2) @(posedge CLK);
			for (i = 0; i < 8; i++)
			begin
				repeat (BT) @(posedge CLK);
				v[i] = SERIAL_OUT;
			end
			repeat (BT) @(posedge CLK);
			if (!SERIAL_OUT) v = 8'hxx;
		end
	endtask
endmodule // upc_line
`default_nettype wire

//--- bench/upc_props.sv
`timescale 1ns/100ps
`default_nettype none
module upc_props #(
	parameter logic [15:0] BIT_DIV = upc_pkg::DIV_DEF	// Clocks per tick minus one
) (
	input wire logic        CLK,
	input wire logic        SRST,
	input wire logic        BVALID,
	input wire logic [1:0]  BRESP,
	input wire logic        RVALID,
	input wire logic [31:0] RDATA,
	input wire logic [1:0]  RRESP,
	input wire logic        CTS_N,
	input wire logic        DSR_N,
	input wire logic        SERIAL_OUT,
	input wire logic        DTR_N,
	input wire logic        RTS_N,
	input wire logic        CLOCK_OUTPUT_PIN,
	input wire logic        TX_BUFFER_EMPTY,
	input wire logic        RX_CHAR_AVAILABLE,
	input wire logic        IRQ_OUTPUT
);
	// One domain, so one clock and one disable
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	// Pins idle on the first edge after reset
	rst_idle_a: assert property ($fell(SRST) |-> SERIAL_OUT && DTR_N && RTS_N &&
		TX_BUFFER_EMPTY && !RX_CHAR_AVAILABLE && !IRQ_OUTPUT && !CLOCK_OUTPUT_PIN)
		else $error("pins not idle after reset");
	// Writes always answer OKAY
	bresp_ok_a: assert property (BVALID |-> BRESP == upc_pkg::RESP_OK)
		else $error("write response not OKAY");
	// Reads always answer OKAY, chip select or not
	rresp_ok_a: assert property (RVALID |-> RRESP == upc_pkg::RESP_OK)
		else $error("read response not OKAY");
	// Byte wide registers, upper bits zero
	rd_upper_a: assert property (RVALID |-> RDATA[31:8] == 24'h0)
		else $error("read upper bits set");
	// Modem control pins move only after a write
	ctl_pin_a: assert property ($changed({DTR_N, RTS_N}) |-> $past(BVALID))
		else $error("control pin moved without write");
	// Buffer empty falls only after a write
	tx_buffer_empty_fall_a: assert property ($fell(TX_BUFFER_EMPTY) |-> $past(BVALID))
		else $error("buffer empty fell without write");
	// Data ready clears only after a read; pin falls one edge after the answer rises
	dr_fall_a: assert property ($fell(RX_CHAR_AVAILABLE) |->
		RVALID || $past(RVALID)) else $error("data ready cleared without read");
	// Interrupt needs a write or a synced modem edge
	irq_cause_a: assert property ($rose(IRQ_OUTPUT) |-> $past(BVALID) ||
		$past(CTS_N, 3) != $past(CTS_N, 5) || $past(DSR_N, 3) != $past(DSR_N, 5))
		else $error("interrupt without cause");
	// A start bit lasts at least eight clocks
	start_len_a: assert property ($fell(SERIAL_OUT) |-> !SERIAL_OUT [*8])
		else $error("start bit too short");
endmodule // upc_props
bind upc_top upc_props #(.BIT_DIV(BIT_DIV)) i_upc_props (.*);
`default_nettype wire

//--- hw/upc_top.sv
// Functional notes
// R1: Serial out high for mark, low space
// R2: Line at mark on CTS false/reset/empty/loop
// R3: CTS and DSR levels readable in status
// R4: CTS/DSR change raises irq when enabled
// R5: No new character while CTS false
// R6: Character in flight finishes despite CTS
// R7: Loop mode ignores CTS
// R8: DSR only affects status and irq
// R9: DTR low when control bit one
// R10: RTS low when control bit one
// R11: Clock out: oscillator or 16x clock (code gives an 8x clock: clk16_r toggles once per 16x tick)
// R12: Reset clears clock-output select bit
// R13: Buffer-empty set on transfer, cleared write
// R14: Reset suspends serial activity, then idle
// R15: Reset clears control; sets empty, complete
// R16: Master and modem enables gate irq
// R17: Receiver ignores input in loop/reset
// R18: Data-ready set when character stored
// R19: Data-ready cleared on read or reset
// R20: Strobes honoured only with chip select
// R21: Master enable false forces irq low
// R22: Loop mode routes tx into receiver
// R23: Bit 0 sent and received first
// R24: Modem inputs synchronised before edge detect
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module upc_top #(
	parameter logic [15:0] BIT_DIV = upc_pkg::DIV_DEF	// Clocks per 16x tick minus one
) (
	input  wire  logic        CLK,
	input  wire  logic        SRST,
	// AXI4-Lite slave
	input  wire  logic [3:0]  AWADDR,
	input  wire  logic        AWVALID,
	output var   logic        AWREADY,
	input  wire  logic [31:0] WDATA,
	input  wire  logic [3:0]  WSTRB,
	input  wire  logic        WVALID,
	output var   logic        WREADY,
	output var   logic [1:0]  BRESP,
	output var   logic        BVALID,
	input  wire  logic        BREADY,
	input  wire  logic [3:0]  ARADDR,
	input  wire  logic        ARVALID,
	output var   logic        ARREADY,
	output var   logic [31:0] RDATA,
	output var   logic [1:0]  RRESP,
	output var   logic        RVALID,
	input  wire  logic        RREADY,
	// Chip select gating bus strobes, active low
	input  wire  logic        CHIP_SELECT_N,
	// Serial and modem pins
	input  wire  logic        OSC_INPUT,
	input  wire  logic        SERIAL_IN,
	output var   logic        SERIAL_OUT,
	input  wire  logic        CTS_N,
	input  wire  logic        DSR_N,
	output var   logic        DTR_N,
	output var   logic        RTS_N,
	output var   logic        CLOCK_OUTPUT_PIN,
	output var   logic        TX_BUFFER_EMPTY,
	output var   logic        RX_CHAR_AVAILABLE,
	output var   logic        IRQ_OUTPUT
);
	// Register state
	logic [7:0]  modem_control_reg_r;	// Modem control
	logic [7:0]  baud_select_reg_r;	// Baud select
	logic [7:0]  tx_holding_register_r;	// Transmit holding
	logic [7:0]  rx_holding_register_r;	// Receive holding
	logic        tx_buffer_empty_r;	// Holding register empty
	logic        tc_r;	// Transmitter fully idle
	logic        dr_r;	// Received character waiting
	logic        mchg_r;	// Modem change latched
	// Synchronisers and edge detect
	logic [1:0]  cts_s_r;	// CTS sync chain
	logic [1:0]  dsr_s_r;	// DSR sync chain
	logic        cts_d_r;	// Last synced CTS
	logic        dsr_d_r;	// Last synced DSR
	logic [1:0]  sin_s_r;	// Serial in sync chain
	logic [1:0]  osc_s_r;	// Oscillator sync chain
	// Baud tick generator
	logic [15:0] div_cnt_r;	// Divider count
	logic        tick;	// 16x tick
	logic        clk16_r;	// 8x clock square wave, toggled on every 16x tick
	// Transmitter
	upc_pkg::upc_tx_e tx_st_r;	// Transmit state
	logic [3:0]  tx_ph_r;	// Oversample phase
	logic [3:0]  tx_bit_r;	// Bit counter
	logic [8:0]  tx_sh_r;	// Shifter incl. start bit
	logic        tx_line;	// Raw transmit level
	// Receiver
	logic        rx_busy_r;	// Character in progress
	logic [3:0]  rx_ph_r;	// Oversample phase
	logic [3:0]  rx_bit_r;	// Bit counter
	logic [7:0]  rx_sh_r;	// Receive shifter
	logic        rx_src;	// Receiver input after loop mux
	// Bus handshake
	logic        aw_got_r;	// Write address held
	logic        w_got_r;	// Write data held
	logic [3:0]  wa_r;	// Held write address
	logic [7:0]  wd_r;	// Held write data low byte
	logic        wstb_r;	// Held low-lane strobe
	logic        wr_fire;	// Write takes effect
	logic        rd_fire;	// Read takes effect
	upc_pkg::upc_rd_s rd_nxt;	// Read answer
	logic        cts_on;	// CTS true after sync
	logic        loop_on;	// Loop test mode active
	logic        tx_load;	// Holding to shifter move

	assign cts_on  = ~cts_s_r[1];
	assign loop_on = modem_control_reg_r[upc_pkg::MC_LOOP];

	// Decode shared by read mux and write side
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a[3:2] == off[3:2]);
	endfunction

	// Two-flop synchronisers; only the second stage is ever looked at
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			cts_s_r <= 2'h3;
			dsr_s_r <= 2'h3;
			sin_s_r <= 2'h3;
			osc_s_r <= 2'h0;
		end
		else
		begin
			cts_s_r <= {cts_s_r[0], CTS_N};	// R24
			dsr_s_r <= {dsr_s_r[0], DSR_N};	// R24
			sin_s_r <= {sin_s_r[0], SERIAL_IN};
			osc_s_r <= {osc_s_r[0], OSC_INPUT};
		end
	end

	// Edge detect history, one flop per modem line
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			cts_d_r <= 1'b1;
			dsr_d_r <= 1'b1;
		end
		else
		begin
			cts_d_r <= cts_s_r[1];
			dsr_d_r <= dsr_s_r[1];
		end
	end

	// 16x tick divider; held cleared in reset so activity is suspended
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			div_cnt_r <= 16'h0000;
			clk16_r   <= 1'b0;
		end
		else if (div_cnt_r >= BIT_DIV)
		begin
			div_cnt_r <= 16'h0000;	// R14
			clk16_r   <= ~clk16_r;
		end
		else
			div_cnt_r <= div_cnt_r + 16'h0001;
	end
	assign tick = (div_cnt_r >= BIT_DIV);

	// AXI write channel capture; address and data taken in either order
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			wa_r     <= 4'h0;
			wd_r     <= 8'h00;
			wstb_r   <= 1'b0;
			BVALID   <= 1'b0;
			BRESP    <= upc_pkg::RESP_OK;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				aw_got_r <= 1'b1;
				wa_r     <= AWADDR;
			end
			if (WVALID && WREADY)
			begin
				w_got_r <= 1'b1;
				wd_r    <= WDATA[7:0];
				wstb_r  <= WSTRB[0];
			end
			if (wr_fire)
			begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				BVALID   <= 1'b1;
				BRESP    <= upc_pkg::RESP_OK;	// All four words are mapped
			end
			else if (BVALID && BREADY)
				BVALID <= 1'b0;
		end
	end
	assign AWREADY = ~aw_got_r & ~BVALID;
	assign WREADY  = ~w_got_r & ~BVALID;
	// Chip select gates the strobe; the bus still completes so it never hangs
	assign wr_fire = aw_got_r & w_got_r & ~BVALID;
	logic wr_eff;	// Write reaches a register
	assign wr_eff = wr_fire & wstb_r & ~CHIP_SELECT_N;	// R20

	// Read mux; upper bits read as zero
	always_comb
	begin
		rd_nxt      = '{data: 32'h0000_0000, resp: upc_pkg::RESP_OK};
		if (hit(ARADDR, upc_pkg::OFF_TXRX))
			rd_nxt.data[7:0] = rx_holding_register_r;
		else if (hit(ARADDR, upc_pkg::OFF_STAT))
		begin
			rd_nxt.data[upc_pkg::ST_DR]   = dr_r;
			rd_nxt.data[upc_pkg::ST_TX_BUFFER_EMPTY] = tx_buffer_empty_r;
			rd_nxt.data[upc_pkg::ST_TC]   = tc_r;
			rd_nxt.data[upc_pkg::ST_MCHG] = mchg_r;
		end
		else if (hit(ARADDR, upc_pkg::OFF_MCTL))
			rd_nxt.data[7:0] = modem_control_reg_r;
		else
		begin
			rd_nxt.data[upc_pkg::MS_CTS] = cts_on;	// R3
			rd_nxt.data[upc_pkg::MS_DSR] = ~dsr_s_r[1];	// R3
		end
	end

	// AXI read channel: answer one cycle after the address is taken
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			RVALID <= 1'b0;
			RDATA  <= 32'h0000_0000;
			RRESP  <= upc_pkg::RESP_OK;
		end
		else if (rd_fire)
		begin
			RVALID <= 1'b1;
			RDATA  <= CHIP_SELECT_N ? 32'h0000_0000 : rd_nxt.data;	// R20
			RRESP  <= rd_nxt.resp;
		end
		else if (RVALID && RREADY)
			RVALID <= 1'b0;
	end
	assign ARREADY = ~RVALID;
	assign rd_fire = ARVALID & ~RVALID;

	// Control registers; reset clears them and the pins they drive
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			modem_control_reg_r <= upc_pkg::MCTL_RST;	// R15
			baud_select_reg_r   <= upc_pkg::BAUD_RST;	// R12
		end
		else if (wr_eff)
		begin
			if (hit(wa_r, upc_pkg::OFF_MCTL))
				modem_control_reg_r <= wd_r;
			if (hit(wa_r, upc_pkg::OFF_BAUD))
				baud_select_reg_r <= wd_r;
		end
	end

	// Transmit holding register and empty flag; a new write wins over a load
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			tx_buffer_empty_r               <= 1'b1;	// R13
			tx_holding_register_r <= 8'h00;
		end
		else if (wr_eff && hit(wa_r, upc_pkg::OFF_TXRX))
		begin
			tx_holding_register_r <= wd_r;
			tx_buffer_empty_r               <= 1'b0;	// R13
		end
		else if (tx_load)
			tx_buffer_empty_r <= 1'b1;	// R13
	end

	// Start only with CTS true, unless looping back
	assign tx_load = (tx_st_r == upc_pkg::TX_IDLE) & ~tx_buffer_empty_r & (cts_on | loop_on);	// R5 R7

	// Transmitter; once shifting, CTS is no longer looked at
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			tx_st_r  <= upc_pkg::TX_IDLE;	// R14
			tx_ph_r  <= 4'h0;
			tx_bit_r <= 4'h0;
			tx_sh_r  <= 9'h1ff;
			tc_r     <= 1'b1;	// R15
		end
		else
		begin
			unique case (tx_st_r)
				upc_pkg::TX_IDLE:
				begin
					if (tx_load)
					begin
						tx_sh_r  <= {tx_holding_register_r, 1'b0};	// R23
						tx_st_r  <= upc_pkg::TX_SHIFT;
						tx_ph_r  <= 4'h0;
						tx_bit_r <= 4'h0;
						tc_r     <= 1'b0;
					end
				end
				upc_pkg::TX_SHIFT:
				begin
					if (tick)
					begin
						tx_ph_r <= tx_ph_r + 4'h1;
						if (tx_ph_r == upc_pkg::OVS)
						begin
							tx_sh_r  <= {1'b1, tx_sh_r[8:1]};	// R23
							tx_bit_r <= tx_bit_r + 4'h1;
							if (tx_bit_r == upc_pkg::FRAME_N - 4'h1)
								tx_st_r <= upc_pkg::TX_STOP;	// R6
						end
					end
				end
				upc_pkg::TX_STOP:
				begin
					if (tick)
					begin
						tx_ph_r <= tx_ph_r + 4'h1;
						if (tx_ph_r == upc_pkg::OVS)
						begin
							tx_st_r <= upc_pkg::TX_IDLE;
							tc_r    <= tx_buffer_empty_r;
						end
					end
				end
				default:
					tx_st_r <= upc_pkg::TX_IDLE;
			endcase
		end
	end
	assign tx_line = (tx_st_r == upc_pkg::TX_SHIFT) ? tx_sh_r[0] : 1'b1;

	// Receiver input: loopback or the synced pin, mark while reset
	assign rx_src = loop_on ? tx_line : sin_s_r[1];	// R17 R22

	// Receiver: mid-bit sampling at 16x, LSB first
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			rx_busy_r <= 1'b0;	// R14
			rx_ph_r   <= 4'h0;
			rx_bit_r  <= 4'h0;
			rx_sh_r   <= 8'h00;
		end
		else if (tick)
		begin
			if (!rx_busy_r)
			begin
				if (!rx_src)	// Low is space: start bit
				begin
					rx_busy_r <= 1'b1;	// R17
					rx_ph_r   <= 4'h1;
					rx_bit_r  <= 4'h0;
				end
			end
			else
			begin
				rx_ph_r <= rx_ph_r + 4'h1;
				if (rx_ph_r == 4'h7)
				begin
					rx_bit_r <= rx_bit_r + 4'h1;
					if (rx_bit_r == 4'h0 && rx_src)
						rx_busy_r <= 1'b0;	// False start, glitch rejected
					else if (rx_bit_r == upc_pkg::FRAME_N)
						rx_busy_r <= 1'b0;	// Stop bit sampled
					else if (rx_bit_r != 4'h0)
						rx_sh_r <= {rx_src, rx_sh_r[7:1]};	// R23
				end
			end
		end
	end

	// Receive holding and data-ready; a new arrival wins over the read
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			dr_r                 <= 1'b0;	// R19
			rx_holding_register_r <= 8'h00;
		end
		else if (tick && rx_busy_r && rx_ph_r == 4'h7 && rx_bit_r == upc_pkg::FRAME_N)
		begin
			rx_holding_register_r <= rx_sh_r;
			dr_r                 <= 1'b1;	// R18
		end
		else if (rd_fire && !CHIP_SELECT_N && hit(ARADDR, upc_pkg::OFF_TXRX))
			dr_r <= 1'b0;	// R19
	end

	// Modem change latch; DSR feeds nothing but this and status
	always_ff @(posedge CLK)
	begin
		if (SRST)
			mchg_r <= 1'b0;
		else if ((cts_s_r[1] ^ cts_d_r) || (dsr_s_r[1] ^ dsr_d_r))
			mchg_r <= 1'b1;	// R4 R8
		else if (rd_fire && !CHIP_SELECT_N && hit(ARADDR, upc_pkg::OFF_BAUD))
			mchg_r <= 1'b0;	// Modem status read clears
	end

	// Pin outputs, all registered
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			SERIAL_OUT        <= 1'b1;	// R2
			DTR_N             <= 1'b1;	// R9
			RTS_N             <= 1'b1;	// R10
			CLOCK_OUTPUT_PIN  <= 1'b0;
			TX_BUFFER_EMPTY   <= 1'b1;	// R13
			RX_CHAR_AVAILABLE <= 1'b0;	// R19
			IRQ_OUTPUT        <= 1'b0;
		end
		else
		begin
			// Mark in loop mode; idle line already mark when empty
			SERIAL_OUT <= loop_on ? 1'b1 : tx_line;	// R1 R2 R22
			DTR_N      <= ~modem_control_reg_r[upc_pkg::MC_DTR];	// R9
			RTS_N      <= ~modem_control_reg_r[upc_pkg::MC_RTS];	// R10
			// Oscillator is sampled, so only slow oscillators pass cleanly
			CLOCK_OUTPUT_PIN <= baud_select_reg_r[upc_pkg::BS_CO] ? clk16_r : osc_s_r[1];	// R11
			TX_BUFFER_EMPTY   <= tx_buffer_empty_r;
			RX_CHAR_AVAILABLE <= dr_r;
			IRQ_OUTPUT <= modem_control_reg_r[upc_pkg::MC_IEN]
				& modem_control_reg_r[upc_pkg::MC_MODEM_IRQ_ENABLE] & mchg_r;	// R16 R21
		end
	end
endmodule // upc_top
`default_nettype wire

//--- shared/upc_pkg.sv
package upc_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [3:0] OFF_TXRX  = 4'h0;	// Transmit holding / receive holding
	localparam logic [3:0] OFF_STAT  = 4'h4;	// uart_status_reg (read)
	localparam logic [3:0] OFF_MCTL  = 4'h8;	// modem_control_reg
	localparam logic [3:0] OFF_BAUD  = 4'hc;	// baud_select_reg (write) / modem status (read)
	// modem_control_reg field positions
	localparam int MC_DTR   = 0;
	localparam int MC_RTS   = 1;
	localparam int MC_LOOP  = 2;
	localparam int MC_IEN   = 3;
	localparam int MC_MODEM_IRQ_ENABLE  = 4;
	// uart_status_reg field positions
	localparam int ST_DR    = 0;
	localparam int ST_TX_BUFFER_EMPTY  = 1;
	localparam int ST_TC    = 2;
	localparam int ST_MCHG  = 3;
	// Modem status field positions
	localparam int MS_CTS   = 0;
	localparam int MS_DSR   = 1;
	// baud_select_reg: clock-output select bit
	localparam int BS_CO    = 7;
	// Reset values
	localparam logic [7:0] MCTL_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	// Bit-time divider default and frame length
	localparam logic [15:0] DIV_DEF  = 16'h0001;
	localparam logic [3:0]  OVS      = 4'hf;	// 16x oversampling, last phase
	localparam logic [3:0]  FRAME_N  = 4'h9;	// Start plus 8 data bits, then stop
	// AXI response codes
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [1:0]
	{
		TX_IDLE  = 2'b00,
		TX_SHIFT = 2'b01,
		TX_STOP  = 2'b10
	} upc_tx_e;
	// Read answer carried together
	typedef struct packed
	{
		logic [31:0] data;
		logic [1:0]  resp;
	} upc_rd_s;
endpackage
